// file: design/tcirq_chan.sv
// Purpose: one channel's source enable and reset-upon-read source status
// Assumes: event inputs are one-cycle pulses on i_clk
// Notes: status latches regardless of enable; enable only gates pending
`timescale 1ns/1ps
`include "tcirq_defines.svh"

module tcirq_chan import tcirq_pkg::*; (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_en_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_sts_rd,
    input wire logic i_cell_ext,
    input wire logic i_cell_ins,
    input wire logic i_ext_ovf,
    input wire logic i_ins_ovf,
    input wire logic i_hec_err,
    input wire logic i_par_err,
    output logic [7:0] o_en,
    output logic [7:0] o_sts,
    output logic o_pend
);

    // incoming causes gathered in register bit order
    wire logic [7:0] evt = {2'b00, i_cell_ext, i_cell_ins, i_ext_ovf, i_ins_ovf, i_hec_err, i_par_err};
    // read clears everything, but a same-cycle event survives
    wire logic [7:0] keep = i_sts_rd ? 8'h00 : o_sts;
    wire logic [7:0] next_sts = keep | evt;
    wire logic [7:0] next_en = i_wdata & `TCIRQ_SRC_WMASK;

    // source enable, bits 7:6 stay zero
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_en <= `TCIRQ_REG_RST;
        end else if (i_en_wr) begin
            o_en <= next_en;
        end
    end

    // sticky cause bits
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sts <= `TCIRQ_REG_RST;
        end else begin
            o_sts <= next_sts;
        end
    end

    // pending when an enabled cause is latched
    assign o_pend = |(o_sts & o_en);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    src_en_ro_a: assert property (o_en[7:6] == 2'b00)
        else $error("source enable reserved bits set");
    ins_set_a: assert property (i_cell_ins |=> o_sts[`TCIRQ_SRC_CELL_INS])
        else $error("cell insertion event not latched");
    rur_clear_a: assert property ((i_sts_rd && !(|evt)) |=> (o_sts == 8'h00))
        else $error("status not cleared by read");
    sticky_hold_a: assert property ((o_sts[4] && !i_sts_rd) |=> o_sts[4])
        else $error("insertion status lost without read");

endmodule : tcirq_chan

// file: design/tcirq_top.sv
// Purpose: two-level interrupt path for transmit cell insertion and its sibling causes
// Assumes: register strobes and event pulses come from logic on i_clk
// Notes: read data appears on o_rdata one cycle after i_rd
//
// Functional notes
// - block enable byte: six writable bits, 2:1 read-only
// - source enable: six cause enables, 7:6 read-only
// - enabled cell insertion raises interrupt per inserted cell
// - block status byte 0 mirrors enable map, read-only
// - block status byte 1 reports control block, bit 7
// - channel indicator flags pending channels in bits 3:0
// - source status bit 4 set, cleared on read
`timescale 1ns/1ps
`include "tcirq_defines.svh"

module tcirq_top import tcirq_pkg::*; (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [3:0] i_cell_ext,
    input wire logic [3:0] i_cell_ins,
    input wire logic [3:0] i_ext_ovf,
    input wire logic [3:0] i_ins_ovf,
    input wire logic [3:0] i_hec_err,
    input wire logic [3:0] i_par_err,
    input wire logic i_rx_atm_irq,
    input wire logic i_rx_toh_irq,
    input wire logic i_rx_poh_irq,
    input wire logic i_rx_ppp_irq,
    input wire logic i_tx_ppp_irq,
    input wire logic i_opctl_irq,
    output logic [7:0] o_rdata,
    output logic o_irq
);

    // map an address onto a register selector
    function automatic tcirq_reg_t reg_decode(input logic [15:0] a);
        logic [3:0] nib;
        logic chan_hit;
        nib = a[15:12] - `TCIRQ_CHAN_NIB_BASE;
        chan_hit = (a[15:12] >= `TCIRQ_CHAN_NIB_BASE) && (nib < 4'(`TCIRQ_NCHAN));
        if (a == `TCIRQ_ADDR_BLK_STS_HI) begin
            return TCIRQ_REG_BLK_STS_HI;
        end else if (a == `TCIRQ_ADDR_BLK_STS_LO) begin
            return TCIRQ_REG_BLK_STS_LO;
        end else if (a == `TCIRQ_ADDR_BLK_EN_LO) begin
            return TCIRQ_REG_BLK_EN;
        end else if (a == `TCIRQ_ADDR_CHAN_IND) begin
            return TCIRQ_REG_CHAN_IND;
        end else if (chan_hit && a[11:0] == `TCIRQ_OFS_SRC_STS) begin
            return TCIRQ_REG_SRC_STS;
        end else if (chan_hit && a[11:0] == `TCIRQ_OFS_SRC_EN) begin
            return TCIRQ_REG_SRC_EN;
        end else begin
            return TCIRQ_REG_NONE;
        end
    endfunction : reg_decode

    // channel index carried in the high address nibble
    function automatic logic [1:0] chan_of(input logic [15:0] a);
        logic [3:0] nib;
        nib = a[15:12] - `TCIRQ_CHAN_NIB_BASE;
        return nib[1:0];
    endfunction : chan_of

    // decoded access
    wire tcirq_reg_t sel = reg_decode(i_addr);
    wire logic [1:0] ch_sel = chan_of(i_addr);
    wire logic blk_en_wr = i_wr && (sel == TCIRQ_REG_BLK_EN);

    logic [7:0] blk_en; // block enable byte 0
    logic [7:0] src_en [`TCIRQ_NCHAN]; // per-channel source enables
    logic [7:0] src_sts [`TCIRQ_NCHAN]; // per-channel cause status
    logic [3:0] chan_pend; // per-channel enabled cause pending

    // block enable byte, reserved bits forced low on write
    wire logic [7:0] next_blk_en = i_wdata & `TCIRQ_BLK_EN_WMASK;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            blk_en <= `TCIRQ_REG_RST;
        end else if (blk_en_wr) begin
            blk_en <= next_blk_en;
        end
    end

    // one enable/status pair per channel
    for (genvar ch = 0; ch < `TCIRQ_NCHAN; ch++) begin : g_chan
        // strobes steered by the channel nibble
        wire logic en_wr = i_wr && (sel == TCIRQ_REG_SRC_EN) && (ch_sel == 2'(ch));
        wire logic sts_rd = i_rd && (sel == TCIRQ_REG_SRC_STS) && (ch_sel == 2'(ch));

        tcirq_chan u_chan (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_en_wr(en_wr),
            .i_wdata(i_wdata),
            .i_sts_rd(sts_rd),
            .i_cell_ext(i_cell_ext[ch]),
            .i_cell_ins(i_cell_ins[ch]),
            .i_ext_ovf(i_ext_ovf[ch]),
            .i_ins_ovf(i_ins_ovf[ch]),
            .i_hec_err(i_hec_err[ch]),
            .i_par_err(i_par_err[ch]),
            .o_en(src_en[ch]),
            .o_sts(src_sts[ch]),
            .o_pend(chan_pend[ch])
        );
    end

    // channel indicator, upper nibble reads zero
    wire logic [7:0] chan_ind = {4'h0, chan_pend};
    // transmit cell block is pending when any channel is
    wire logic tx_atm_pend = |chan_pend;

    // block status byte 0, same layout as the enable byte
    wire logic [7:0] blk_sts_lo = {i_rx_atm_irq, i_rx_toh_irq, i_rx_poh_irq, i_rx_ppp_irq,
                                   tx_atm_pend, 2'b00, i_tx_ppp_irq};
    // block status byte 1, control block has no enable in this map
    wire logic [7:0] blk_sts_hi = {i_opctl_irq, 7'h00};

    // blocks gated by their enable; control block always passes
    wire logic irq_any = (|(blk_sts_lo & blk_en)) || blk_sts_hi[`TCIRQ_BLK_OPCTL];

    // read multiplexer; unmapped addresses read zero
    logic [7:0] next_rdata;
    always_comb begin
        case (sel)
            TCIRQ_REG_BLK_STS_HI: next_rdata = blk_sts_hi;
            TCIRQ_REG_BLK_STS_LO: next_rdata = blk_sts_lo;
            TCIRQ_REG_BLK_EN: next_rdata = blk_en;
            TCIRQ_REG_CHAN_IND: next_rdata = chan_ind;
            TCIRQ_REG_SRC_STS: next_rdata = src_sts[ch_sel];
            TCIRQ_REG_SRC_EN: next_rdata = src_en[ch_sel];
            default: next_rdata = 8'h00;
        endcase
    end

    // read data captured on the strobe; it is the pre-clear value
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end
    end

    // registered interrupt: one cycle of lag buys a glitch-free pin
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= irq_any;
        end
    end

    // checks below
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // enabled insertion on channel 0 with no host access in between
    sequence ins_event_s;
        blk_en[`TCIRQ_BLK_TX_ATM] && src_en[0][`TCIRQ_SRC_CELL_INS] && i_cell_ins[0] && !i_wr;
    endsequence
    sequence quiet_s;
        !i_wr && !i_rd;
    endsequence

    blk_en_ro_a: assert property (blk_en[2:1] == 2'b00)
        else $error("block enable reserved bits set");
    blk_en_write_a: assert property (blk_en_wr |=> blk_en == ($past(i_wdata) & `TCIRQ_BLK_EN_WMASK))
        else $error("block enable write not stored");
    ins_irq_a: assert property ((ins_event_s ##1 quiet_s) |=> o_irq)
        else $error("cell insertion did not raise interrupt");
    blk_sts_tx_a: assert property (blk_sts_lo[3] == (|((src_sts[0] & src_en[0]) | (src_sts[1] & src_en[1])
                                    | (src_sts[2] & src_en[2]) | (src_sts[3] & src_en[3]))))
        else $error("block status bit 3 wrong");
    sts_hi_read_a: assert property ((i_rd && i_addr == `TCIRQ_ADDR_BLK_STS_HI)
                                    |=> o_rdata == {$past(i_opctl_irq), 7'h00})
        else $error("block status byte 1 read wrong");
    chan_ind_read_a: assert property ((i_rd && i_addr == `TCIRQ_ADDR_CHAN_IND)
                                      |=> o_rdata == {4'h0, $past(chan_pend)})
        else $error("channel indicator read wrong");
    rur_read_a: assert property ((i_rd && sel == TCIRQ_REG_SRC_STS && ch_sel == 2'd0 && !i_cell_ins[0]
                                  && src_sts[0][4]) |=> (o_rdata[4] && !src_sts[0][4]))
        else $error("source status not returned then cleared");
    irq_on_a: assert property ((blk_en[3] && tx_atm_pend) |=> o_irq)
        else $error("interrupt missing while pending");
    irq_off_a: assert property ((!(|(blk_sts_lo & blk_en)) && !i_opctl_irq) |=> !o_irq)
        else $error("interrupt asserted with nothing pending");
    unmapped_a: assert property ((i_rd && sel == TCIRQ_REG_NONE) |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");

endmodule : tcirq_top

// file: inc/tcirq_defines.svh
// Purpose: constants for the transmit cell interrupt path
// Assumes: 16-bit register addresses, 8-bit register data
// Notes: per-channel source registers sit at {channel nibble, low offset}
`ifndef TCIRQ_DEFINES_SVH
`define TCIRQ_DEFINES_SVH

// number of transmit cell processor channels
`define TCIRQ_NCHAN 4

// common register addresses
`define TCIRQ_ADDR_BLK_STS_HI 16'h0012
`define TCIRQ_ADDR_BLK_STS_LO 16'h0013
`define TCIRQ_ADDR_BLK_EN_LO 16'h0017
`define TCIRQ_ADDR_CHAN_IND 16'h0122

// per-channel source registers: high nibble selects the channel
`define TCIRQ_OFS_SRC_STS 12'hF0B
`define TCIRQ_OFS_SRC_EN 12'hF0F
`define TCIRQ_CHAN_NIB_BASE 4'h1

// block enable / status byte 0 bit positions
`define TCIRQ_BLK_RX_ATM 7
`define TCIRQ_BLK_RX_TOH 6
`define TCIRQ_BLK_RX_POH 5
`define TCIRQ_BLK_RX_PPP 4
`define TCIRQ_BLK_TX_ATM 3
`define TCIRQ_BLK_TX_PPP 0
`define TCIRQ_BLK_EN_WMASK 8'hF9

// block status byte 1
`define TCIRQ_BLK_OPCTL 7

// source enable / status bit positions
`define TCIRQ_SRC_CELL_EXT 5
`define TCIRQ_SRC_CELL_INS 4
`define TCIRQ_SRC_EXT_OVF 3
`define TCIRQ_SRC_INS_OVF 2
`define TCIRQ_SRC_HEC_ERR 1
`define TCIRQ_SRC_PAR_ERR 0
`define TCIRQ_SRC_WMASK 8'h3F

// reset value of every enable and status register
`define TCIRQ_REG_RST 8'h00

`endif

// file: inc/tcirq_pkg.sv
// Purpose: types shared by the transmit cell interrupt path
// Assumes: tcirq_defines.svh holds the numbers
// Notes: register selector produced by the address decode
package tcirq_pkg;

    // which register an address points at
    typedef enum logic [2:0] {
        TCIRQ_REG_NONE,
        TCIRQ_REG_BLK_STS_HI,
        TCIRQ_REG_BLK_STS_LO,
        TCIRQ_REG_BLK_EN,
        TCIRQ_REG_CHAN_IND,
        TCIRQ_REG_SRC_STS,
        TCIRQ_REG_SRC_EN
    } tcirq_reg_t;

endpackage : tcirq_pkg

// file: verification/tcirq_host.sv
// Purpose: host model that arms and services the transmit cell interrupt
// Assumes: strobes taken at a rising edge, read data valid one cycle later
// Notes: idle bus lines show the inverse of the last value
`timescale 1ns/1ps
`include "tcirq_defines.svh"

module tcirq_host (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [15:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    logic [1:0] chan; // channel picked from the indicator

    // quiet bus at time zero
    initial begin
        o_addr = 16'h0000;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // channel register address: high nibble picks the channel
    function automatic logic [15:0] src_a(input logic [1:0] c, input logic [11:0] ofs);
        return {`TCIRQ_CHAN_NIB_BASE + {2'h0, c}, ofs};
    endfunction : src_a

    // one write; lines flipped after so stale values never pass for valid ones
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask : wr

    // one read; returns once read data has landed
    task automatic rd(input logic [15:0] a);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
    endtask : rd

    // arm cell insertion interrupt: block enable bit 3, then source enable bit 4 of channel c
    task automatic arm_ins(input logic [1:0] c);
        wr(`TCIRQ_ADDR_BLK_EN_LO, 8'h08);
        wr(src_a(c, `TCIRQ_OFS_SRC_EN), 8'h10);
    endtask : arm_ins

    // service routine: both block bytes, indicator, then cause register
    task automatic isr;
        rd(`TCIRQ_ADDR_BLK_STS_HI);
        rd(`TCIRQ_ADDR_BLK_STS_LO);
        rd(`TCIRQ_ADDR_CHAN_IND);
        chan = i_rdata[0] ? 2'h0 : i_rdata[1] ? 2'h1 : i_rdata[2] ? 2'h2 : 2'h3;
        rd(src_a(chan, `TCIRQ_OFS_SRC_STS));
    endtask : isr
endmodule : tcirq_host

// file: verification/tcirq_top_bench.sv
// Purpose: self-checking bench for the transmit cell interrupt path
// Assumes: host model drives the register bus, bench drives event pulses
// Notes: read results are queued and compared at the falling edge
`timescale 1ns/1ps
`include "tcirq_defines.svh"
// one compare: counts it, and prints one line on a mismatch
`define CHK(a, e) begin \
    comparisons++; \
    if ((a) !== (e)) begin \
        mismatches++; \
        $display("BAD %0t got %h want %h", $time, a, e); \
    end \
end

module tcirq_top_bench;
    logic clk, nrst, wr, rd, opctl, irq, rd_seen;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, r, en, sl, exp8;
    logic [3:0] ev [6]; // event pulses, index is the cause bit
    logic [4:0] oth; // other blocks' requests
    logic [7:0] exp_q [$]; // expected read data, oldest first
    int seed = 32'h4003;
    int mismatches = 0;
    int comparisons = 0;
    localparam logic [15:0] RST_A [7] = '{16'h0012, 16'h0013, 16'h0017, 16'h0122, 16'h1F0B, 16'h1F0F, 16'h0055};

    tcirq_top tcirq_top_inst (.i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .i_cell_ext(ev[5]), .i_cell_ins(ev[4]), .i_ext_ovf(ev[3]), .i_ins_ovf(ev[2]), .i_hec_err(ev[1]),
        .i_par_err(ev[0]), .i_rx_atm_irq(oth[4]), .i_rx_toh_irq(oth[3]), .i_rx_poh_irq(oth[2]),
        .i_rx_ppp_irq(oth[1]), .i_tx_ppp_irq(oth[0]), .i_opctl_irq(opctl), .o_rdata(rdata), .o_irq(irq));
    tcirq_host tcirq_host_inst (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // read monitor: one queued note per taken read
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            exp8 = exp_q.pop_front();
            `CHK(rdata, exp8)
        end
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // note expected data, then read
    task automatic chk_rd(input logic [15:0] a, input logic [7:0] v);
        exp_q.push_back(v);
        tcirq_host_inst.rd(a);
    endtask : chk_rd

    // one-cycle event on cause b of channel c
    task automatic pulse(input int b, input logic [1:0] c);
        @(posedge clk);
        ev[b][c] <= 1'b1;
        @(posedge clk);
        ev[b][c] <= 1'b0;
    endtask : pulse

    // hang guard, far beyond the expected run
    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end

    // main sequence
    initial begin
        nrst = 1'b0;
        ev = '{default: 4'h0};
        oth = 5'h00;
        opctl = 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        // reset values, unmapped write ignored
        tcirq_host_inst.wr(16'h0055, 8'hFF);
        foreach (RST_A[i]) chk_rd(RST_A[i], 8'h00);
        // read-only bits of both enable kinds ignore writes
        for (int c = 0; c < 4; c++) begin
            r = 8'($random(seed));
            tcirq_host_inst.wr(tcirq_host_inst.src_a(c[1:0], `TCIRQ_OFS_SRC_EN), r);
            chk_rd(tcirq_host_inst.src_a(c[1:0], `TCIRQ_OFS_SRC_EN), r & 8'h3F);
        end
        r = 8'($random(seed));
        en = (r | 8'h06) & 8'hF9;
        tcirq_host_inst.wr(`TCIRQ_ADDR_BLK_EN_LO, r | 8'h06);
        chk_rd(`TCIRQ_ADDR_BLK_EN_LO, en);
        // other blocks' levels show raw in block status, gated into irq except the control block
        @(posedge clk);
        oth <= r[4:0] ^ 5'h1B;
        opctl <= r[7];
        @(posedge clk);
        sl = {oth[4:1], 3'b000, oth[0]};
        chk_rd(`TCIRQ_ADDR_BLK_STS_LO, sl);
        chk_rd(`TCIRQ_ADDR_BLK_STS_HI, {opctl, 7'h00});
        `CHK(irq, (|(sl & en)) | opctl)
        // drop the other blocks' levels on a rising edge
        @(posedge clk);
        oth <= 5'h00;
        opctl <= 1'b0;
        // insertion interrupt raised, serviced and cleared on each channel
        for (int c = 0; c < 4; c++) begin
            tcirq_host_inst.arm_ins(c[1:0]);
            pulse(4, c[1:0]);
            repeat (3) @(posedge clk);
            #1 `CHK(irq, 1'b1)
            exp_q = {exp_q, 8'h00, 8'h08, 8'h01 << c, 8'h10};
            tcirq_host_inst.isr();
            repeat (2) @(posedge clk);
            #1 `CHK(irq, 1'b0)
            chk_rd(tcirq_host_inst.src_a(c[1:0], `TCIRQ_OFS_SRC_STS), 8'h00);
        end
        // every cause latches; block enable off keeps irq low
        tcirq_host_inst.wr(`TCIRQ_ADDR_BLK_EN_LO, 8'h00);
        for (int b = 0; b < 6; b++) begin
            tcirq_host_inst.wr(tcirq_host_inst.src_a(b[1:0], `TCIRQ_OFS_SRC_EN), 8'h3F);
            pulse(b, b[1:0]);
            chk_rd(`TCIRQ_ADDR_BLK_STS_LO, 8'h08);
            `CHK(irq, 1'b0)
            chk_rd(tcirq_host_inst.src_a(b[1:0], `TCIRQ_OFS_SRC_STS), 8'h01 << b);
        end
        repeat (2) @(posedge clk);
        wrap_up();
    end
endmodule : tcirq_top_bench
